// ### verilog/adcop_pkg.sv
package adcop_pkg;

  // register addresses on the serial port
  localparam logic [3:0] ADDR_OPERATING_SETUP          = 4'h6;
  localparam logic [3:0] ADDR_START_DELAY_FILTER_SETUP = 4'h7;

  // reset values
  localparam logic [7:0] OPERATING_SETUP_RST          = 8'h00;
  localparam logic [7:0] START_DELAY_FILTER_SETUP_RST = 8'h00;

  // operating_setup field positions
  localparam int RANGE_WIDEN_BIT    = 7;
  localparam int RESERVED_BIT       = 6;
  localparam int SERIAL_OUT_FN_BIT  = 5;
  localparam int START_MODE_HI      = 4;
  localparam int START_MODE_LO      = 3;
  localparam int SPEED_BIT          = 2;
  localparam int AUTO_SLEEP_BIT     = 1;
  localparam int FULL_POWER_OFF_BIT = 0;
  localparam logic [7:0] OPERATING_SETUP_WMASK = 8'hBF;

  // start_delay_filter_setup field positions
  localparam int DELAY_HI = 7;
  localparam int DELAY_LO = 5;

  // start pin control codes
  localparam logic [1:0] START_STOP_CTRL = 2'h0;
  localparam logic [1:0] ONE_SHOT_CTRL   = 2'h1;
  localparam logic [1:0] SYNC_CTRL       = 2'h2;

  // serial frame layout
  localparam int          FRAME_BITS   = 16;
  localparam logic [4:0]  CMD_LAST_BIT = 5'h07;
  localparam logic [4:0]  FRAME_END    = 5'h10;
  localparam int          READ_FLAG    = 7;

  // timing: modulator clock is half the device clock
  localparam int MCLK_PER_MOD = 2;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_DELAY = 3'h2,
    ST_CONV  = 3'h4
  } adcop_state_t;

  // synchronised pin group
  typedef struct packed {
    logic [2:0] sclk_s;
    logic [2:0] cs_n_s;
    logic [2:0] sdi_s;
    logic [2:0] start_s;
    logic       sclk_q;
    logic       cs_n_q;
    logic       start_q;
    logic       sdi_q;
  } adcop_pins_t;

  typedef struct packed {
    adcop_pins_t  pins;
    logic [4:0]   bit_cnt;
    logic [15:0]  rx;
    logic [7:0]   tx;
    logic         sdo_q;
    logic         pin_q;
    logic         pin_oe_q;
    logic [7:0]   operating_setup;
    logic [7:0]   start_delay_filter_setup;
    logic         drdy;
    adcop_state_t state;
    logic [11:0]  dly_cnt;
    logic         conv_begin;
  } adcop_state_all_t;

endpackage : adcop_pkg

// ### verilog/adcop_regs.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - range_widen_bit set widens input full scale by a quarter, clear gives standard.
// - serial_out_pin_function 0 data only, 1 data plus ready indication.
// - start mode field 4:3: start/stop, one-shot, synchronized, reserved.
// - speed bit 0 high speed 25.6 MHz, 1 low speed 3.2 MHz.
// - auto sleep clear keeps device fully powered when idle.
// - auto sleep set enters standby when stopped, leaves on restart.
// - full_power_off powers down all but serial port, registers kept.
// - wait programmed modulator_clock cycles, half device clock, before first conversion.
// - delay codes map to 0,4,8,16,32,128,512,1024 modulator cycles.
// - start_delay_filter_setup at address 7, resets to zero.
// - operating_setup resets to all zero fields.
// - one-shot runs one conversion; start/stop runs until stop after current.
module adcop_regs (
  // clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_nrst,
  // serial register port
  input  wire logic       i_sclk,
  input  wire logic       i_cs_n,
  input  wire logic       i_sdi,
  output logic            o_data_out_ready_pin,
  output logic            o_data_out_ready_pin_oe,
  // conversion control
  input  wire logic       i_start,
  input  wire logic       i_conv_done,
  output logic            o_conv_begin,
  output logic            o_converting,
  output logic            o_delaying,
  // analog configuration
  output logic            o_range_widen,
  output logic            o_low_speed,
  output logic            o_analog_on,
  output logic            o_standby,
  output logic            o_full_power_off,
  output logic [4:0]      o_filter_select
);

  adcop_pkg::adcop_state_all_t s_reg;
  adcop_pkg::adcop_state_all_t s_next;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // device clock cycles of start delay
  // longest code is 2048 device cycles, so 12 bits suffice
  function automatic logic [11:0] delay_mclk(input logic [2:0] code);
    logic [11:0] mod_cyc;
    mod_cyc = 12'h000;
    case (code)
      3'h0:    mod_cyc = 12'h000;
      3'h1:    mod_cyc = 12'h004;
      3'h2:    mod_cyc = 12'h008;
      3'h3:    mod_cyc = 12'h010;
      3'h4:    mod_cyc = 12'h020;
      3'h5:    mod_cyc = 12'h080;
      3'h6:    mod_cyc = 12'h200;
      default: mod_cyc = 12'h400;
    endcase
    return 12'(mod_cyc * adcop_pkg::MCLK_PER_MOD);
  endfunction : delay_mclk

  // unmapped addresses read back as zero
  function automatic logic [7:0] read_reg(input logic [3:0] addr,
                                          input logic [7:0] op,
                                          input logic [7:0] dl);
    logic [7:0] v;
    v = 8'h00;
    if (addr == adcop_pkg::ADDR_OPERATING_SETUP) begin
      v = op & adcop_pkg::OPERATING_SETUP_WMASK;
    end else if (addr == adcop_pkg::ADDR_START_DELAY_FILTER_SETUP) begin
      v = dl;
    end else begin
      v = 8'h00;
    end
    return v;
  endfunction : read_reg

  // filtered level: follows once second and third stage agree
  function automatic logic filt(input logic [2:0] sy, input logic q);
    return (sy[1] == sy[2]) ? sy[2] : q;
  endfunction : filt

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic       sclk_n;
    logic       cs_n_n;
    logic       start_n;
    logic       sdi_n;
    logic       sclk_rise;
    logic       sclk_fall;
    logic       cs_fall;
    logic       start_rise;
    logic [1:0] mode;
    logic       trig;
    logic       restart;
    logic       pwr_off;
    logic [15:0] frame;
    sclk_n     = 1'b0;
    cs_n_n     = 1'b1;
    start_n    = 1'b0;
    sdi_n      = 1'b0;
    sclk_rise  = 1'b0;
    sclk_fall  = 1'b0;
    cs_fall    = 1'b0;
    start_rise = 1'b0;
    mode       = 2'h0;
    trig       = 1'b0;
    restart    = 1'b0;
    pwr_off    = 1'b0;
    frame      = 16'h0000;
    s_next     = s_reg;

    // three-stage pin synchronisers
    s_next.pins.sclk_s  = {s_reg.pins.sclk_s[1:0], i_sclk};
    s_next.pins.cs_n_s  = {s_reg.pins.cs_n_s[1:0], i_cs_n};
    s_next.pins.sdi_s   = {s_reg.pins.sdi_s[1:0], i_sdi};
    s_next.pins.start_s = {s_reg.pins.start_s[1:0], i_start};
    sclk_n  = filt(s_reg.pins.sclk_s, s_reg.pins.sclk_q);
    cs_n_n  = filt(s_reg.pins.cs_n_s, s_reg.pins.cs_n_q);
    start_n = filt(s_reg.pins.start_s, s_reg.pins.start_q);
    sdi_n   = filt(s_reg.pins.sdi_s, s_reg.pins.sdi_q);
    s_next.pins.sclk_q  = sclk_n;
    s_next.pins.cs_n_q  = cs_n_n;
    s_next.pins.start_q = start_n;
    s_next.pins.sdi_q   = sdi_n;
    // edges count only inside a frame, so idle sclk wiggle is harmless
    sclk_rise  = sclk_n & ~s_reg.pins.sclk_q & ~cs_n_n;
    sclk_fall  = ~sclk_n & s_reg.pins.sclk_q & ~cs_n_n;
    cs_fall    = ~cs_n_n & s_reg.pins.cs_n_q;
    start_rise = start_n & ~s_reg.pins.start_q;

    // serial frame: command byte then data byte, msb first
    if (cs_fall) begin
      s_next.bit_cnt = 5'h00;
      s_next.tx      = 8'h00;
      s_next.sdo_q   = 1'b0;
    end else if (sclk_rise && s_reg.bit_cnt != adcop_pkg::FRAME_END) begin
      frame          = {s_reg.rx[14:0], sdi_n};
      s_next.rx      = frame;
      s_next.bit_cnt = 5'(s_reg.bit_cnt + 5'h01);
      if (s_reg.bit_cnt == adcop_pkg::CMD_LAST_BIT && frame[adcop_pkg::READ_FLAG]) begin
        s_next.tx = read_reg(frame[3:0], s_reg.operating_setup,
                             s_reg.start_delay_filter_setup);
      end
      // write lands only on a complete frame
      if (5'(s_reg.bit_cnt + 5'h01) == adcop_pkg::FRAME_END
          && !frame[8 + adcop_pkg::READ_FLAG]) begin
        if (frame[11:8] == adcop_pkg::ADDR_OPERATING_SETUP) begin
          s_next.operating_setup = frame[7:0] & adcop_pkg::OPERATING_SETUP_WMASK;
        end else if (frame[11:8] == adcop_pkg::ADDR_START_DELAY_FILTER_SETUP) begin
          s_next.start_delay_filter_setup = frame[7:0];
        end
      end
    end else if (sclk_fall && s_reg.bit_cnt > adcop_pkg::CMD_LAST_BIT) begin
      s_next.sdo_q = s_reg.tx[7];
      s_next.tx    = {s_reg.tx[6:0], 1'b0};
    end

    // conversion sequencing
    mode    = s_reg.operating_setup[adcop_pkg::START_MODE_HI:adcop_pkg::START_MODE_LO];
    pwr_off = s_reg.operating_setup[adcop_pkg::FULL_POWER_OFF_BIT];
    trig    = 1'b0;
    restart = 1'b0;
    // start/stop follows the level, one-shot and synchronized the rising edge
    case (mode)
      adcop_pkg::START_STOP_CTRL: begin
        trig    = start_n;
        restart = start_rise;
      end
      adcop_pkg::ONE_SHOT_CTRL: begin
        trig    = start_rise;
        restart = start_rise;
      end
      adcop_pkg::SYNC_CTRL: begin
        trig    = start_rise;
        restart = start_rise;
      end
      default: begin
        trig    = 1'b0;
        restart = 1'b0;
      end
    endcase
    s_next.conv_begin = 1'b0;
    case (s_reg.state)
      adcop_pkg::ST_IDLE: begin
        if (trig && !pwr_off) begin
          s_next.state   = adcop_pkg::ST_DELAY;
          s_next.dly_cnt = delay_mclk(s_reg.start_delay_filter_setup[
                             adcop_pkg::DELAY_HI:adcop_pkg::DELAY_LO]);
        end
      end
      adcop_pkg::ST_DELAY: begin
        // a zero count still spends one cycle here, begin stays registered
        if (s_reg.dly_cnt == 12'h000) begin
          s_next.state      = adcop_pkg::ST_CONV;
          s_next.conv_begin = 1'b1;
        end else begin
          s_next.dly_cnt = 12'(s_reg.dly_cnt - 12'h001);
        end
      end
      adcop_pkg::ST_CONV: begin
        if (restart) begin
          s_next.state   = adcop_pkg::ST_DELAY;
          s_next.dly_cnt = delay_mclk(s_reg.start_delay_filter_setup[
                             adcop_pkg::DELAY_HI:adcop_pkg::DELAY_LO]);
        end else if (i_conv_done) begin
          // stop request honoured only at a conversion boundary
          if (mode == adcop_pkg::ONE_SHOT_CTRL
              || (mode == adcop_pkg::START_STOP_CTRL && !start_n)) begin
            s_next.state = adcop_pkg::ST_IDLE;
          end else begin
            s_next.conv_begin = 1'b1;
          end
        end
      end
      default: begin
        s_next.state = adcop_pkg::ST_IDLE;
      end
    endcase
    // power off overrides any start or restart
    if (pwr_off) begin
      s_next.state      = adcop_pkg::ST_IDLE;
      s_next.conv_begin = 1'b0;
    end

    // ready flag: new data sets, frame start clears, set wins
    if (cs_fall) begin
      s_next.drdy = 1'b0;
    end
    if (i_conv_done && s_reg.state == adcop_pkg::ST_CONV) begin
      s_next.drdy = 1'b1;
    end

    // pin: data while selected, inverted ready when deselected in dual mode
    if (!cs_n_n) begin
      s_next.pin_q    = s_next.sdo_q;
      s_next.pin_oe_q = 1'b1;
    end else if (s_reg.operating_setup[adcop_pkg::SERIAL_OUT_FN_BIT]) begin
      s_next.pin_q    = ~s_next.drdy;
      s_next.pin_oe_q = 1'b1;
    end else begin
      // released pin lets chained parts share the line
      s_next.pin_q    = 1'b0;
      s_next.pin_oe_q = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      s_reg.pins.sclk_s             <= 3'h0;
      s_reg.pins.cs_n_s             <= 3'h7;
      s_reg.pins.sdi_s              <= 3'h0;
      s_reg.pins.start_s            <= 3'h0;
      s_reg.pins.sclk_q             <= 1'b0;
      s_reg.pins.cs_n_q             <= 1'b1;
      s_reg.pins.start_q            <= 1'b0;
      s_reg.pins.sdi_q              <= 1'b0;
      s_reg.bit_cnt                 <= 5'h00;
      s_reg.rx                      <= 16'h0000;
      s_reg.tx                      <= 8'h00;
      s_reg.sdo_q                   <= 1'b0;
      s_reg.pin_q                   <= 1'b0;
      s_reg.pin_oe_q                <= 1'b0;
      s_reg.operating_setup         <= adcop_pkg::OPERATING_SETUP_RST;
      s_reg.start_delay_filter_setup <= adcop_pkg::START_DELAY_FILTER_SETUP_RST;
      s_reg.drdy                    <= 1'b0;
      s_reg.state                   <= adcop_pkg::ST_IDLE;
      s_reg.dly_cnt                 <= 12'h000;
      s_reg.conv_begin              <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign o_data_out_ready_pin    = s_reg.pin_q;
  assign o_data_out_ready_pin_oe = s_reg.pin_oe_q;
  assign o_conv_begin            = s_reg.conv_begin;
  assign o_converting            = s_reg.state == adcop_pkg::ST_CONV;
  assign o_delaying              = s_reg.state == adcop_pkg::ST_DELAY;
  assign o_range_widen    = s_reg.operating_setup[adcop_pkg::RANGE_WIDEN_BIT];
  assign o_low_speed      = s_reg.operating_setup[adcop_pkg::SPEED_BIT];
  assign o_full_power_off = s_reg.operating_setup[adcop_pkg::FULL_POWER_OFF_BIT];
  // standby only while stopped, so a new start wakes it at once
  assign o_standby = s_reg.operating_setup[adcop_pkg::AUTO_SLEEP_BIT]
                     && s_reg.state == adcop_pkg::ST_IDLE && !o_full_power_off;
  assign o_analog_on     = !o_full_power_off && !o_standby;
  assign o_filter_select = s_reg.start_delay_filter_setup[4:0];

endmodule : adcop_regs

// ### sim/adcop_monitor.sv
`timescale 1ns/1ps
module adcop_monitor (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // watched ports
  input wire logic i_cs_n,
  input wire logic i_conv_done,
  input wire logic o_data_out_ready_pin_oe,
  input wire logic o_conv_begin,
  input wire logic o_converting,
  input wire logic o_delaying,
  input wire logic o_standby,
  input wire logic o_analog_on,
  input wire logic o_full_power_off
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_nrst);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_idle;
    !o_converting && !o_delaying;
  endsequence
  sequence s_delay_end;
    $fell(o_delaying) ##0 !o_full_power_off;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_begin_in_conv: assert property (o_conv_begin |-> o_converting)
    else $error("begin outside conversion");
  a_begin_single: assert property (o_conv_begin |=> !o_conv_begin)
    else $error("begin pulse too long");
  a_delay_then_conv: assert property (s_delay_end |-> o_converting && o_conv_begin)
    else $error("delay ended without conversion");
  a_off_forces_idle: assert property (o_full_power_off |=> s_idle)
    else $error("active while powered off");
  a_off_analog_down: assert property (o_full_power_off |-> !o_analog_on && !o_standby)
    else $error("analog on while powered off");
  a_standby_quiet: assert property (o_standby |-> s_idle ##0 !o_analog_on)
    else $error("standby while busy");
  a_busy_awake: assert property (o_converting || o_delaying |-> !o_standby)
    else $error("standby during conversion");
  a_oe_on_select: assert property ($fell(i_cs_n) |-> ##[1:6] o_data_out_ready_pin_oe)
    else $error("pin not driven in frame");
  a_conv_holds: assert property (o_converting && !i_conv_done && !o_full_power_off
    |=> o_converting || o_delaying)
    else $error("conversion dropped early");
endmodule : adcop_monitor

bind adcop_regs adcop_monitor u_mon (.i_mclk, .i_nrst, .i_cs_n, .i_conv_done,
  .o_data_out_ready_pin_oe, .o_conv_begin, .o_converting, .o_delaying, .o_standby,
  .o_analog_on, .o_full_power_off);

// ### sim/adcop_host.sv
`timescale 1ns/1ps
module adcop_host (
  // device pin
  input  wire logic i_pin,
  // serial port
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_sdi
);
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_sdi  = 1'b0;
  end
  // sclk rests low between frames; sdi flips so a stale bit is never seen
  task automatic xfer(input logic [15:0] f, input int nb, output logic [7:0] rd);
    int i;
    rd = 8'h00;
    o_cs_n = 1'b0;
    #400;
    for (i = 15; i > 15 - nb; i--) begin
      o_sdi = f[i];
      #160 o_sclk = 1'b1;
      // read bit lands late in the low phase, so sample just before the fall
      #160 if (i < 8) rd[i] = i_pin;
      o_sclk = 1'b0;
    end
    #400 o_cs_n = 1'b1;
    o_sdi = ~o_sdi;
    #400;
  endtask : xfer
endmodule : adcop_host

// ### sim/tb_adcop_regs.sv
`timescale 1ns/1ps
module tb_adcop_regs;
  logic       i_mclk, i_nrst, i_start, i_conv_done, sclk, cs_n, sdi, pin, oe;
  logic       cbeg, conv, dly, rw, ls, aon, sby, off, b, pin_line;
  logic [4:0] fsel;
  logic [7:0] d, op, dl;
  int         n_mismatch, n_tests, cyc, i, t, ew, nd;
  localparam int DLY[8] = '{0, 4, 8, 16, 32, 128, 512, 1024};
  adcop_regs dut (.i_mclk, .i_nrst, .i_sclk(sclk), .i_cs_n(cs_n), .i_sdi(sdi),
    .o_data_out_ready_pin(pin), .o_data_out_ready_pin_oe(oe), .i_start, .i_conv_done,
    .o_conv_begin(cbeg), .o_converting(conv), .o_delaying(dly), .o_range_widen(rw),
    .o_low_speed(ls), .o_analog_on(aon), .o_standby(sby), .o_full_power_off(off),
    .o_filter_select(fsel));
  // undriven line shows the inverse, so a dropped enable is caught
  assign pin_line = oe ? pin : ~pin;
  adcop_host host (.i_pin(pin_line), .o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    i_mclk = 1'b0;
    forever #20 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      stop_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic int wait_of(input logic [2:0] c);
    return adcop_pkg::MCLK_PER_MOD * DLY[c];
  endfunction : wait_of
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp
  task automatic cmpb(input logic g, input logic e);
    cmp({7'h00, g}, {7'h00, e});
  endtask : cmpb
  task automatic tick(input int n);
    repeat (n) @(negedge i_mclk);
  endtask : tick
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    host.xfer({4'h0, a, v}, 16, d);
  endtask : wr
  task automatic rdr(input logic [3:0] a, output logic [7:0] v);
    host.xfer({4'h8, a, 8'h00}, 16, v);
  endtask : rdr
  task automatic trig(output int n);
    n = 0;
    nd = 0;
    i_start = 1'b1;
    while (cbeg !== 1'b1 && n < 3000) begin
      tick(1);
      n++;
      if (dly === 1'b1)
        nd++;
    end
  endtask : trig
  task automatic done_pulse();
    // a conversion never ends in the cycle it began
    tick(2);
    i_conv_done = 1'b1;
    tick(1);
    i_conv_done = 1'b0;
    b = cbeg;
    tick(1);
    b = b | cbeg;
  endtask : done_pulse
  task automatic stop_test();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {i_nrst, i_start, i_conv_done, cyc, n_mismatch, n_tests} = '0;
    void'($urandom(32'h63CC0742));
    tick(2);
    i_nrst = 1'b1;
    tick(4);
    rdr(4'h6, d);
    cmp(d, adcop_pkg::OPERATING_SETUP_RST);
    rdr(4'h7, d);
    cmp(d, 8'h00);
    cmpb(aon, 1'b1);
    for (i = 0; i < 12; i++) begin
      op = $urandom;
      dl = $urandom;
      if (op[4:3] == 2'h3) op[4] = 1'b0;
      wr(4'h6, op);
      wr(4'h7, dl);
      rdr(4'h6, d);
      cmp(d, op & adcop_pkg::OPERATING_SETUP_WMASK);
      rdr(4'h7, d);
      cmp(d, dl);
      cmp({rw, ls, off, fsel}, {op[7], op[2], op[0], dl[4:0]});
      cmp({sby, aon, oe}, {op[1] & ~op[0], ~op[1] & ~op[0], op[5]});
    end
    // unmapped address must read back zero, and a cut-short frame must leave operating_setup alone
    wr(4'h9, 8'hFF);
    rdr(4'h9, d);
    cmp(d, 8'h00);
    host.xfer({8'h06, 8'hFF}, 12, d);
    rdr(4'h6, d);
    cmp(d, op & adcop_pkg::OPERATING_SETUP_WMASK);
    // one-shot, auto sleep, dual pin; every delay code
    wr(4'h6, 8'h2A);
    for (i = 0; i < 8; i++) begin
      wr(4'h7, {i[2:0], 5'h00});
      ew = wait_of(i[2:0]);
      cmpb(sby, 1'b1);
      trig(t);
      cmpb(t >= ew + 4 && t <= ew + 6, 1'b1);
      cmpb(nd == ew + 1, 1'b1);
      cmp({sby, pin, oe}, 3'h3);
      done_pulse();
      tick(1);
      cmp({conv, pin, oe}, 3'h1);
      i_start = 1'b0;
      tick(6);
    end
    // start/stop: runs on while start is high, stops after current one
    wr(4'h7, 8'h00);
    // data-only pin function, as a chained converter would use
    wr(4'h6, 8'h00);
    trig(t);
    cmp({sby, aon}, 2'h1);
    done_pulse();
    cmp({b, conv}, 2'h3);
    i_start = 1'b0;
    tick(6);
    cmpb(conv, 1'b1);
    done_pulse();
    cmpb(conv, 1'b0);
    // synchronized mode, then power off stops it
    wr(4'h6, 8'h10);
    trig(t);
    cmpb(t <= 8, 1'b1);
    wr(4'h6, 8'h01);
    cmp({conv, dly, aon}, 3'h0);
    i_start = 1'b0;
    tick(6);
    // reserved start code and power off both refuse a start
    for (i = 0; i < 2; i++) begin
      wr(4'h6, i ? 8'h01 : 8'h18);
      i_start = 1'b1;
      tick(40);
      cmp({conv, dly}, 2'h0);
      i_start = 1'b0;
      tick(6);
    end
    // mid-run reset puts both registers back to their reset values
    wr(4'h7, 8'hA5);
    i_nrst = 1'b0;
    tick(2);
    i_nrst = 1'b1;
    tick(4);
    rdr(4'h6, d);
    cmp(d, adcop_pkg::OPERATING_SETUP_RST);
    rdr(4'h7, d);
    cmp(d, adcop_pkg::START_DELAY_FILTER_SETUP_RST);
    cmp({off, aon, fsel}, 7'h20);
    stop_test();
  end
endmodule : tb_adcop_regs
